// ==== logic/rcc_pkg.sv ====
// holds constants and types shared by the clock reference control block
// assumes a single mclk domain at 40 MHz
package rcc_pkg;

  // ----------------------------------------
  // oscillator nominal rates
  // ----------------------------------------
  localparam int unsigned RCC_SLOW_RC_HZ = 64000;
  localparam int unsigned RCC_FAST_RC_HZ = 13000000;
  localparam int unsigned RCC_MCLK_HZ = 40000000;

  // ----------------------------------------
  // trim register map and values
  // ----------------------------------------
  localparam logic [15:0] RCC_ADDR_TRIM_A = 16'h0911;
  localparam logic [15:0] RCC_ADDR_TRIM_B = 16'h0912;
  localparam logic [7:0] RCC_TRIM_POR = 8'h05;
  localparam logic [7:0] RCC_TRIM_CRYSTAL_OSCILLATOR_STBY = 8'h12;
  localparam logic [7:0] RCC_TRIM_MIN = 8'h00;
  localparam logic [7:0] RCC_TRIM_MAX = 8'h2F;

  // ----------------------------------------
  // command argument fields
  // ----------------------------------------
  localparam int unsigned RCC_SLEEP_WARM_BIT = 0;
  localparam int unsigned RCC_SLEEP_RTC_BIT = 1;
  localparam int unsigned RCC_VOLT_W = 3;
  localparam int unsigned RCC_TICK_W = 24;
  localparam logic [RCC_TICK_W-1:0] RCC_TICKS_ONE = 24'h000001;

  // ----------------------------------------
  // synchroniser depth for the slow rc pin
  // ----------------------------------------
  localparam int unsigned RCC_SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    RCC_OP_NOP,
    RCC_OP_WRITE_REG,
    RCC_OP_READ_REG,
    RCC_OP_SLEEP,
    RCC_OP_STDBY_RC,
    RCC_OP_CRYSTAL_STANDBY_STATE,
    RCC_OP_SET_AUX_SUPPLY
  } rcc_op_e;

  typedef enum logic [1:0] {
    RCC_ST_SLEEP,
    RCC_ST_STDBY_RC,
    RCC_ST_CRYSTAL_STANDBY_STATE
  } rcc_state_e;

endpackage

// ==== logic/rcc_rtc_if.sv ====
// carries the wake timer request and its answer between the two modules
// assumes both ends run on mclk
`timescale 1ns/1ps
interface rcc_rtc_if;
  import rcc_pkg::*;
  logic start;
  logic abort;
  logic [RCC_TICK_W-1:0] ticks;
  logic busy;
  logic expire;
  modport owner (output start, output abort, output ticks,
                 input busy, input expire);
  modport timer (input start, input abort, input ticks,
                 output busy, output expire);
endinterface

// ==== logic/rcc_rtc_timer.sv ====
// counts slow rc oscillator edges to time wake events
// assumes slow_rc_clk arrives asynchronously from the oscillator
`timescale 1ns/1ps
module rcc_rtc_timer
  import rcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow_rc_clk,
  rcc_rtc_if.timer rtc
);

  logic [RCC_SYNC_STAGES-1:0] sync;
  logic level;
  logic [RCC_TICK_W-1:0] count;
  logic busy;
  logic expire;

  // ----------------------------------------
  // pin synchroniser and filter
  // ----------------------------------------
  wire agree = sync[1] == sync[2];
  wire next_level = agree ? sync[2] : level;
  wire tick = next_level && !level;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync <= '0;
      level <= 1'b0;
    end else begin
      sync <= {sync[1:0], slow_rc_clk};
      level <= next_level;
    end
  end

  // ----------------------------------------
  // down counter
  // ----------------------------------------
  wire [RCC_TICK_W-1:0] load =
    (rtc.ticks == '0) ? RCC_TICKS_ONE : rtc.ticks;
  wire done = busy && tick && (count == RCC_TICKS_ONE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
      busy <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= done && !rtc.abort && !rtc.start;
      if (rtc.start) begin
        count <= load;
        busy <= 1'b1;
      end else if (rtc.abort || done) begin
        busy <= 1'b0;
      end else if (busy && tick) begin
        count <= count - RCC_TICKS_ONE;
      end
    end
  end

  assign rtc.busy = busy;
  assign rtc.expire = expire;

  property p_rtc_expire;
    @(posedge mclk) disable iff (rst)
    expire |-> $past(busy) && $past(count) == RCC_TICKS_ONE && !busy;
  endproperty
  a_rtc_expire: assert property (p_rtc_expire)
    else $error("wake timer expired without counting out");

endmodule

// ==== logic/rcc_clock_ref.sv ====
// clock reference control: rc oscillator enables, crystal or
// compensated oscillator selection, crystal trim registers
// assumes commands arrive decoded from the serial port on mclk
`timescale 1ns/1ps

// Operation
// - slow and fast rc oscillators, independent
// - slow rc wakes device from sleep
// - timed events counted on slow rc
// - fast rc on during serial traffic
// - reference from crystal or compensated oscillator
// - two independent trim capacitors
// - trim a at 0x0911, b at 0x0912
// - linear code, 0x00 to 0x2F
// - power on or cold wake loads 0x05
// - entering crystal standby writes 0x12
// - aux supply command sets trim a 0x2F
// - aux pin supplies oscillator, programmed level
// - compensated mode held until chip reset
module rcc_clock_ref
  import rcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow_rc_clk,
  input wire logic spi_busy,
  input wire logic cmd_valid,
  input wire rcc_op_e cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [RCC_TICK_W-1:0] cmd_arg,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] crystal_trim_a,
  output logic [7:0] crystal_trim_b,
  output logic slow_rc_osc_en,
  output logic fast_rc_osc_en,
  output logic crystal_oscillator_en,
  output logic compensated_oscillator_sel,
  output logic [RCC_VOLT_W-1:0] aux_supply_level,
  output logic aux_io_pin_out,
  output logic aux_io_pin_oe_n,
  output logic asleep
);

  rcc_state_e state;
  rcc_state_e next_state;
  logic warm;
  logic rtc_wake;
  logic compensated_oscillator_mode;

  rcc_rtc_if rtc ();

  rcc_rtc_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .slow_rc_clk(slow_rc_clk),
    .rtc(rtc)
  );

  function automatic logic [7:0] sat_trim(input logic [7:0] code);
    return (code > RCC_TRIM_MAX) ? RCC_TRIM_MAX : code;
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire do_wr = cmd_valid && cmd_op == RCC_OP_WRITE_REG;
  wire do_rd = cmd_valid && cmd_op == RCC_OP_READ_REG;
  wire do_sleep = cmd_valid && cmd_op == RCC_OP_SLEEP;
  wire do_rc = cmd_valid && cmd_op == RCC_OP_STDBY_RC;
  wire do_crystal_oscillator = cmd_valid && cmd_op == RCC_OP_CRYSTAL_STANDBY_STATE;
  wire do_aux = cmd_valid && cmd_op == RCC_OP_SET_AUX_SUPPLY;
  wire sel_a = cmd_addr == RCC_ADDR_TRIM_A;
  wire sel_b = cmd_addr == RCC_ADDR_TRIM_B;
  wire in_sleep = state == RCC_ST_SLEEP;
  wire wake = in_sleep && (cmd_valid || rtc.expire);
  wire wake_cold = wake && !warm;
  wire enter_crystal_oscillator = do_crystal_oscillator && state != RCC_ST_CRYSTAL_STANDBY_STATE;

  // ----------------------------------------
  // state sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      RCC_ST_SLEEP: begin
        if (wake) begin
          next_state = RCC_ST_STDBY_RC;
        end
      end
      RCC_ST_STDBY_RC, RCC_ST_CRYSTAL_STANDBY_STATE: begin
        next_state = state;
      end
      default: begin
        next_state = RCC_ST_STDBY_RC;
      end
    endcase
    if (do_sleep) begin
      next_state = RCC_ST_SLEEP;
    end else if (do_crystal_oscillator) begin
      next_state = RCC_ST_CRYSTAL_STANDBY_STATE;
    end else if (do_rc) begin
      next_state = RCC_ST_STDBY_RC;
    end
  end

  // ----------------------------------------
  // trim register updates
  // ----------------------------------------
  // independent trim values
  wire [7:0] next_trim_a =
    do_aux ? RCC_TRIM_MAX :
    (do_wr && sel_a) ? sat_trim(cmd_data) :
    enter_crystal_oscillator ? RCC_TRIM_CRYSTAL_OSCILLATOR_STBY :
    wake_cold ? RCC_TRIM_POR : crystal_trim_a;
  wire [7:0] next_trim_b =
    (do_wr && sel_b) ? sat_trim(cmd_data) :
    enter_crystal_oscillator ? RCC_TRIM_CRYSTAL_OSCILLATOR_STBY :
    wake_cold ? RCC_TRIM_POR : crystal_trim_b;
  wire [7:0] read_value =
    sel_a ? crystal_trim_a : sel_b ? crystal_trim_b : 8'h00;
  wire next_compensated_oscillator = compensated_oscillator_mode || do_aux;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crystal_trim_a <= RCC_TRIM_POR;
      crystal_trim_b <= RCC_TRIM_POR;
    end else begin
      crystal_trim_a <= next_trim_a;
      crystal_trim_b <= next_trim_b;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= RCC_ST_STDBY_RC;
      warm <= 1'b0;
      rtc_wake <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      state <= next_state;
      rd_valid <= do_rd;
      if (do_rd) begin
        rd_data <= read_value;
      end
      if (do_sleep) begin
        warm <= cmd_data[RCC_SLEEP_WARM_BIT];
        rtc_wake <= cmd_data[RCC_SLEEP_RTC_BIT];
      end else if (wake) begin
        rtc_wake <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compensated_oscillator_mode <= 1'b0;
      aux_supply_level <= '0;
      crystal_oscillator_en <= 1'b0;
    end else begin
      compensated_oscillator_mode <= next_compensated_oscillator;
      if (do_aux) begin
        aux_supply_level <= cmd_data[RCC_VOLT_W-1:0];
      end
      crystal_oscillator_en <=
        next_state == RCC_ST_CRYSTAL_STANDBY_STATE && !next_compensated_oscillator;
    end
  end

  // ----------------------------------------
  // wake timer and outputs
  // ----------------------------------------
  // sleep timer start
  assign rtc.start = do_sleep && cmd_data[RCC_SLEEP_RTC_BIT];
  assign rtc.ticks = cmd_arg;
  assign rtc.abort = in_sleep && cmd_valid;

  assign slow_rc_osc_en = in_sleep && rtc_wake;
  assign fast_rc_osc_en = spi_busy || cmd_valid || !in_sleep;
  assign compensated_oscillator_sel = compensated_oscillator_mode;
  assign aux_io_pin_out = compensated_oscillator_mode;
  assign aux_io_pin_oe_n = !compensated_oscillator_mode;
  assign asleep = in_sleep;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // cold wake reload
  property p_cold_wake;
    @(posedge mclk) disable iff (rst)
    wake_cold && !cmd_valid |=>
      crystal_trim_a == RCC_TRIM_POR && crystal_trim_b == RCC_TRIM_POR;
  endproperty
  a_cold_wake: assert property (p_cold_wake)
    else $error("cold wake did not reload trims");

  property p_crystal_oscillator_overwrite;
    @(posedge mclk) disable iff (rst)
    enter_crystal_oscillator |=> crystal_trim_a == RCC_TRIM_CRYSTAL_OSCILLATOR_STBY &&
      crystal_trim_b == RCC_TRIM_CRYSTAL_OSCILLATOR_STBY &&
      state == RCC_ST_CRYSTAL_STANDBY_STATE;
  endproperty
  a_crystal_oscillator_overwrite: assert property (p_crystal_oscillator_overwrite)
    else $error("crystal standby entry did not overwrite trims");

  property p_aux_trim;
    @(posedge mclk) disable iff (rst)
    do_aux |=> crystal_trim_a == RCC_TRIM_MAX && compensated_oscillator_mode &&
      crystal_trim_b == ($past(wake_cold) ? RCC_TRIM_POR :
      $past(crystal_trim_b));
  endproperty
  a_aux_trim: assert property (p_aux_trim)
    else $error("aux supply command did not set trim a");

  property p_compensated_oscillator_sticky;
    @(posedge mclk) disable iff (rst)
    compensated_oscillator_mode |=> compensated_oscillator_mode [*4];
  endproperty
  a_compensated_oscillator_sticky: assert property (p_compensated_oscillator_sticky)
    else $error("compensated mode dropped without reset");

  property p_ref_excl;
    @(posedge mclk) disable iff (rst)
    crystal_oscillator_en |-> !compensated_oscillator_sel &&
      state == RCC_ST_CRYSTAL_STANDBY_STATE;
  endproperty
  a_ref_excl: assert property (p_ref_excl)
    else $error("crystal enabled alongside compensated source");

  property p_fast_rc;
    @(posedge mclk) disable iff (rst)
    spi_busy || cmd_valid |-> fast_rc_osc_en;
  endproperty
  a_fast_rc: assert property (p_fast_rc)
    else $error("fast rc off during serial traffic");

  property p_trim_range;
    @(posedge mclk) disable iff (rst)
    do_wr && sel_b |=> crystal_trim_b == ($past(cmd_data) > RCC_TRIM_MAX ?
      RCC_TRIM_MAX : $past(cmd_data));
  endproperty
  a_trim_range: assert property (p_trim_range)
    else $error("trim b write out of range or lost");

  property p_read_a;
    @(posedge mclk) disable iff (rst)
    do_rd && sel_a |=> rd_valid && rd_data == $past(crystal_trim_a);
  endproperty
  a_read_a: assert property (p_read_a)
    else $error("read of trim a returned wrong value");

  property p_aux_drive;
    @(posedge mclk) disable iff (rst)
    do_aux |=> !aux_io_pin_oe_n && aux_io_pin_out &&
      aux_supply_level == $past(cmd_data[RCC_VOLT_W-1:0]);
  endproperty
  a_aux_drive: assert property (p_aux_drive)
    else $error("aux pin not driving programmed supply");

  property p_slow_rc;
    @(posedge mclk) disable iff (rst)
    rtc.busy && in_sleep |-> slow_rc_osc_en;
  endproperty
  a_slow_rc: assert property (p_slow_rc)
    else $error("slow rc off while sleep timer runs");

endmodule

// ==== test/rcc_host_model.sv ====
// host model that configures the clock block through decoded commands
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
module rcc_host_model
  import rcc_pkg::*;
(
  input wire logic mclk,
  output logic rst,
  output logic spi_busy,
  output logic cmd_valid,
  output rcc_op_e cmd_op,
  output logic [15:0] cmd_addr,
  output logic [7:0] cmd_data,
  output logic [RCC_TICK_W-1:0] cmd_arg
);
  initial begin
    rst = 1'b1;
    spi_busy = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = RCC_OP_NOP;
    cmd_addr = 16'h0000;
    cmd_data = 8'h00;
    cmd_arg = '0;
  end

  // full reset to leave compensated mode
  task automatic chip_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // one command strobe, then the fields go stale
  task automatic issue(input rcc_op_e op, input logic [15:0] a,
                       input logic [7:0] d, input logic [23:0] n);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_arg <= n;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    #1;
  endtask

  // enters crystal standby first, then writes the trim
  task automatic set_trim(input logic [15:0] a, input logic [7:0] d);
    issue(RCC_OP_CRYSTAL_STANDBY_STATE, 16'h0000, 8'h00, 24'h000000);
    issue(RCC_OP_WRITE_REG, a, d, 24'h000000);
  endtask

  task automatic set_busy(input logic b);
    @(posedge mclk);
    spi_busy <= b;
    #1;
  endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the clock reference control block
// assumes the host model drives every command input
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, got, exp); end end
module tb
  import rcc_pkg::*;
;
  logic mclk, slow_rc_clk, rst, spi_busy, cmd_valid, rd_valid;
  rcc_op_e cmd_op;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data, rd_data, trim_a, trim_b;
  logic [RCC_TICK_W-1:0] cmd_arg;
  logic slow_en, fast_en, xo_en, tc_sel, aux_out, aux_oe_n, asleep;
  logic [RCC_VOLT_W-1:0] aux_lvl;
  int err_count = 0;
  int checked = 0;

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    slow_rc_clk = 1'b0;
    forever #7812.5 slow_rc_clk = ~slow_rc_clk;
  end

  rcc_host_model host (.mclk(mclk), .rst(rst), .spi_busy(spi_busy),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_arg(cmd_arg));

  rcc_clock_ref dut (.mclk(mclk), .rst(rst), .slow_rc_clk(slow_rc_clk),
    .spi_busy(spi_busy), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_arg(cmd_arg),
    .rd_data(rd_data), .rd_valid(rd_valid), .crystal_trim_a(trim_a),
    .crystal_trim_b(trim_b), .slow_rc_osc_en(slow_en),
    .fast_rc_osc_en(fast_en), .crystal_oscillator_en(xo_en),
    .compensated_oscillator_sel(tc_sel), .aux_supply_level(aux_lvl),
    .aux_io_pin_out(aux_out), .aux_io_pin_oe_n(aux_oe_n),
    .asleep(asleep));

  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host.issue(RCC_OP_READ_REG, a, 8'h00, 24'h000000);
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask

  task automatic t_reset_values();
    `CHK({trim_a, trim_b}, 16'h0505)
    `CHK({fast_en, slow_en, asleep}, 3'h4)
    `CHK({xo_en, tc_sel, aux_oe_n}, 3'h1)
  endtask

  task automatic t_crystal_oscillator_trim();
    host.issue(RCC_OP_CRYSTAL_STANDBY_STATE, 16'h0000, 8'h00, 24'h000000);
    `CHK({trim_a, trim_b}, 16'h1212)
    `CHK(xo_en, 1'b1)
    host.issue(RCC_OP_WRITE_REG, RCC_ADDR_TRIM_A, 8'h20, 24'h000000);
    host.issue(RCC_OP_WRITE_REG, RCC_ADDR_TRIM_B, 8'h2F, 24'h000000);
    `CHK({trim_a, trim_b}, 16'h202F)
    rd(RCC_ADDR_TRIM_A, 8'h20);
    rd(RCC_ADDR_TRIM_B, 8'h2F);
    host.issue(RCC_OP_WRITE_REG, RCC_ADDR_TRIM_B, 8'h30, 24'h000000);
    host.issue(RCC_OP_WRITE_REG, RCC_ADDR_TRIM_A, 8'h00, 24'h000000);
    `CHK({trim_a, trim_b}, 16'h002F)
    host.issue(RCC_OP_WRITE_REG, 16'h0913, 8'h55, 24'h000000);
    rd(16'h0913, 8'h00);
    host.issue(RCC_OP_CRYSTAL_STANDBY_STATE, 16'h0000, 8'h00, 24'h000000);
    `CHK({trim_a, trim_b}, 16'h002F)
  endtask

  task automatic t_sleep(input logic [7:0] d, input logic [23:0] n,
                         input logic [15:0] et, input int min_n);
    int c;
    host.issue(RCC_OP_SLEEP, 16'h0000, d, n);
    `CHK({asleep, slow_en, fast_en}, {1'b1, d[1], 1'b0})
    host.set_busy(1'b1);
    `CHK(fast_en, 1'b1)
    host.set_busy(1'b0);
    c = 0;
    while (asleep === 1'b1 && c < 4000) begin
      @(posedge mclk);
      #1;
      c++;
    end
    #1;
    `CHK(c >= min_n && c < 4000, 1'b1)
    `CHK({asleep, slow_en}, 2'b00)
    `CHK({trim_a, trim_b}, et)
  endtask

  task automatic t_aux();
    host.issue(RCC_OP_SET_AUX_SUPPLY, 16'h0000, 8'h05, 24'h000000);
    `CHK({trim_a, trim_b}, 16'h2F12)
    `CHK({tc_sel, xo_en}, 2'b10)
    `CHK({aux_out, aux_oe_n, aux_lvl}, 5'h15)
    host.issue(RCC_OP_STDBY_RC, 16'h0000, 8'h00, 24'h000000);
    host.issue(RCC_OP_CRYSTAL_STANDBY_STATE, 16'h0000, 8'h00, 24'h000000);
    `CHK({tc_sel, xo_en}, 2'b10)
    t_sleep(8'h02, 24'h000001, 16'h0505, 0);
    `CHK(tc_sel, 1'b1)
    host.chip_reset();
    `CHK({tc_sel, aux_out, aux_oe_n}, 3'h1)
  endtask

  task automatic t_cmd_wake();
    host.issue(RCC_OP_SLEEP, 16'h0000, 8'h02, 24'h000100);
    `CHK({asleep, slow_en}, 2'b11)
    host.issue(RCC_OP_WRITE_REG, RCC_ADDR_TRIM_A, 8'h07, 24'h000000);
    `CHK({asleep, slow_en, fast_en}, 3'h1)
    `CHK({trim_a, trim_b}, 16'h0705)
  endtask

  initial begin
    host.chip_reset();
    t_reset_values();
    t_crystal_oscillator_trim();
    t_sleep(8'h02, 24'h000002, 16'h0505, 500);
    host.set_trim(RCC_ADDR_TRIM_A, 8'h1A);
    `CHK({trim_a, trim_b}, 16'h1A12)
    t_sleep(8'h03, 24'h000001, 16'h1A12, 0);
    t_aux();
    t_cmd_wake();
    tally_and_finish();
  end

  initial begin
    #1000000;
    err_count++;
    tally_and_finish();
  end
endmodule
